//--- hdl/lpm_consts.vh
// Constants for the low-power mode controller
`ifndef LPM_CONSTS_VH
`define LPM_CONSTS_VH
// Register byte offsets
`define OFS_MODE_CTRL 8'h00
`define OFS_MODE_STAT 8'h04
`define OFS_IRQ_STAT 8'h08
`define OFS_IRQ_MASK 8'h0C
`define OFS_BACKUP_BASE 8'h40
`define OFS_BACKUP_LAST 8'h64
// Mode control fields
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 1
`define CTRL_STOP_LP_BIT 2
`define CTRL_DET_EN_BIT 3
`define CTRL_SRC_LSB 4
`define CTRL_SRC_MSB 5
`define CTRL_RESET_VAL 6'h00
// Requested low-power modes
`define REQ_SLEEP 2'h0
`define REQ_STOP 2'h1
`define REQ_STANDBY 2'h2
// System clock sources
`define SRC_INT_RC 2'h0
`define SRC_EXT_OSC 2'h1
`define SRC_PLL 2'h2
// Regulator states
`define REG_MAIN 2'h0
`define REG_LOW_POWER 2'h1
`define REG_POWER_DOWN 2'h2
// Interrupt status bits
`define IRQ_DET_BIT 0
`define IRQ_STOP_WAKE_BIT 1
`define IRQ_STANDBY_BIT 2
`define IRQ_SLEEP_WAKE_BIT 3
`define IRQ_WIDTH 4
`define IRQ_RESET_VAL 4'h0
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

//--- hdl/backup_store.v
// Backup-domain user register memory with registered read data
`timescale 1ns/1ps
module backup_store #(
    parameter DEPTH = 10,
    parameter WIDTH = 16,
    parameter AW = 4
) (
    input wire aclk,
    input wire backup_resetn,
    input wire we,
    input wire [WIDTH/8-1:0] be,
    input wire [AW-1:0] waddr,
    input wire [WIDTH-1:0] wdata,
    input wire [AW-1:0] raddr,
    output reg [WIDTH-1:0] rdata
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    integer i;
    integer b;

    // Own reset so a core-domain reset leaves contents alone
    always @(posedge aclk)
    begin
        if (!backup_resetn)
        begin
            for (i = 0; i < DEPTH; i = i + 1)
                mem[i] <= {WIDTH{1'b0}};
            rdata <= {WIDTH{1'b0}};
        end
        else
        begin
            if (we && (waddr < DEPTH))
            begin
                for (b = 0; b < WIDTH/8; b = b + 1)
                    if (be[b])
                        mem[waddr][b*8 +: 8] <= wdata[b*8 +: 8];
            end
            rdata <= (raddr < DEPTH) ? mem[raddr] : {WIDTH{1'b0}};
        end
    end
endmodule // backup_store

//--- hdl/low_power_mode_controller.v
// Power-mode sequencer with regulator control, wake logic and AXI4-Lite registers
// Operation
// [RL1] Regulator has main, low-power, power-down states
// [RL2] Run mode uses main regulation
// [RL3] Stop mode may use low-power regulation
// [RL4] Standby powers regulator down, core state lost
// [RL5] Regulator enabled after reset, off in Standby
// [RL6] Sleep halts core clock only
// [RL7] Any peripheral interrupt wakes Sleep
// [RL8] Stop halts core clocks and fast oscillators
// [RL9] Stop keeps all register contents; src_r is set back to the internal RC on wake
// [RL10] Stop regulator selectable main or low-power
// [RL11] Any event line wakes Stop
// [RL12] Standby switches regulator and oscillators off
// [RL13] Standby loses state except backup registers; the standby flag in the interrupt status is kept too
// [RL14] Standby exits on reset, watchdog, pin, alarm
// [RL15] Calendar and watchdog clocks always run
// [RL16] Threshold detector off until software enables
// [RL17] Ten 16-bit retained backup registers
// [RL18] Stop/Standby wake uses internal RC clock
// [RL19] Software sets mode before wait instruction
`timescale 1ns/1ps
`include "lpm_consts.vh"
module low_power_mode_controller #(
    parameter EVENT_LINES = 16,
    parameter BACKUP_DEPTH = 10
) (
    input wire aclk,
    input wire aresetn,
    input wire backup_resetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire wait_request,
    input wire periph_event,
    input wire [EVENT_LINES-1:0] event_lines,
    input wire supply_threshold_detector,
    input wire calendar_alarm,
    input wire wakeup_pin,
    input wire independent_watchdog_reset,
    input wire external_reset_pin_n,
    output wire core_clk_en,
    output wire periph_clk_en,
    output wire pll_en,
    output wire high_speed_internal_oscillator_en,
    output wire high_speed_external_oscillator_en,
    output wire always_on_clk_en,
    output wire regulator_en,
    output wire [1:0] regulator_mode,
    output wire [1:0] sys_clk_src,
    output wire core_domain_resetn,
    output wire irq
);
    localparam ST_RUN = 2'd0;
    localparam ST_SLEEP = 2'd1;
    localparam ST_STOP = 2'd2;
    localparam ST_STANDBY = 2'd3;

    function is_hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            is_hit = (addr == ofs);
        end
    endfunction

    function is_backup;
        input [7:0] addr;
        begin
            is_backup = (addr >= `OFS_BACKUP_BASE) && (addr <= `OFS_BACKUP_LAST)
                && (addr[1:0] == 2'b00);
        end
    endfunction

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [5:0] ctrl_r;
    reg [1:0] src_r;
    reg [`IRQ_WIDTH-1:0] irq_stat_r;
    reg [`IRQ_WIDTH-1:0] irq_mask_r;
    reg det_prev_r;
    reg wakeup_pin_prev_r;
    reg core_rst_r;
    reg aw_full_r;
    reg w_full_r;
    reg [7:0] aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg bvalid_r;
    reg [1:0] bresp_r;
    reg rd_pend_r;
    reg [7:0] rd_addr_r;
    reg rvalid_r;
    reg [1:0] rresp_r;
    reg [31:0] rdata_r;
    reg [31:0] rd_mux;
    wire [15:0] bk_rdata;
    wire rd_known;

    wire [1:0] req_mode = ctrl_r[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
    wire stop_lp = ctrl_r[`CTRL_STOP_LP_BIT];
    wire det_en = ctrl_r[`CTRL_DET_EN_BIT];

    // Register write path
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire aw_ok = aw_full_r || aw_hs;
    wire w_ok = w_full_r || w_hs;
    wire wr_go = aw_ok && w_ok;
    wire [7:0] wr_addr = aw_full_r ? aw_addr_r : s_axi_awaddr;
    wire [31:0] wr_data = w_full_r ? w_data_r : s_axi_wdata;
    wire [3:0] wr_strb = w_full_r ? w_strb_r : s_axi_wstrb;
    wire wr_ctrl = wr_go && is_hit(wr_addr, `OFS_MODE_CTRL) && wr_strb[0];
    wire wr_stat = wr_go && is_hit(wr_addr, `OFS_IRQ_STAT) && wr_strb[0];
    wire wr_mask = wr_go && is_hit(wr_addr, `OFS_IRQ_MASK) && wr_strb[0];
    wire wr_bk = wr_go && is_backup(wr_addr);
    wire wr_known = is_hit(wr_addr, `OFS_MODE_CTRL) || is_hit(wr_addr, `OFS_MODE_STAT)
        || is_hit(wr_addr, `OFS_IRQ_STAT) || is_hit(wr_addr, `OFS_IRQ_MASK)
        || is_backup(wr_addr);
    wire [7:0] wr_bk_ofs = wr_addr - `OFS_BACKUP_BASE;
    wire [7:0] rd_bk_ofs = s_axi_araddr - `OFS_BACKUP_BASE;

    assign s_axi_awready = !aw_full_r && !bvalid_r;
    assign s_axi_wready = !w_full_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rd_pend_r && !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    wire ar_hs = s_axi_arvalid && s_axi_arready;

    // Wake source decoding
    wire det_cross = det_en && (supply_threshold_detector != det_prev_r);
    wire any_event = (|event_lines) || calendar_alarm || (det_en && supply_threshold_detector);
    wire wakeup_pin_rise = wakeup_pin && !wakeup_pin_prev_r;
    wire standby_exit = !external_reset_pin_n || independent_watchdog_reset || wakeup_pin_rise
        || calendar_alarm;

    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN:
            begin
                // Mode chosen beforehand by software
                // [RL19] mode set before wait
                if (wait_request)
                begin
                    case (req_mode)
                        `REQ_SLEEP: state_nxt = ST_SLEEP;
                        `REQ_STOP: state_nxt = ST_STOP;
                        `REQ_STANDBY: state_nxt = ST_STANDBY;
                        default: state_nxt = ST_SLEEP;
                    endcase
                end
            end
            ST_SLEEP:
            begin
                // [RL7] peripheral event wakes
                if (periph_event || any_event)
                    state_nxt = ST_RUN;
            end
            ST_STOP:
            begin
                // [RL11] any event line wakes
                if (any_event)
                    state_nxt = ST_RUN;
            end
            ST_STANDBY:
            begin
                // [RL14] standby exit sources
                if (standby_exit)
                    state_nxt = ST_RUN;
            end
            default: state_nxt = ST_RUN;
        endcase
    end

    wire stop_wake = (state_r == ST_STOP) && (state_nxt == ST_RUN);
    wire sleep_wake = (state_r == ST_SLEEP) && (state_nxt == ST_RUN);
    wire standby_wake = (state_r == ST_STANDBY) && (state_nxt == ST_RUN);
    wire [`IRQ_WIDTH-1:0] irq_set = {sleep_wake, standby_wake, stop_wake, det_cross};

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= ST_RUN;
            ctrl_r <= `CTRL_RESET_VAL;
            src_r <= `SRC_INT_RC;
            irq_stat_r <= `IRQ_RESET_VAL;
            irq_mask_r <= `IRQ_RESET_VAL;
            det_prev_r <= 1'b0;
            wakeup_pin_prev_r <= 1'b0;
            core_rst_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            det_prev_r <= supply_threshold_detector;
            wakeup_pin_prev_r <= wakeup_pin;
            // [RL13] core state lost, standby flag kept
            core_rst_r <= standby_wake;
            if (core_rst_r)
            begin
                ctrl_r <= `CTRL_RESET_VAL;
                irq_mask_r <= `IRQ_RESET_VAL;
                // New events still land during the core reset
                irq_stat_r <= (irq_stat_r & (`IRQ_RESET_VAL | (4'h1 << `IRQ_STANDBY_BIT)))
                    | irq_set;
            end
            else
            begin
                // [RL9] stop holds every register except src_r, which goes back to the internal RC on wake
                if (wr_ctrl)
                    ctrl_r <= wr_data[5:0];
                if (wr_mask)
                    irq_mask_r <= wr_data[`IRQ_WIDTH-1:0];
                // Set wins over a same-cycle clear
                // [RL16] detector crossing interrupt
                irq_stat_r <= (irq_stat_r & ~(wr_stat ? wr_data[`IRQ_WIDTH-1:0]
                    : `IRQ_RESET_VAL)) | irq_set;
            end
            // [RL18] wake clock source
            if (stop_wake || standby_wake)
                src_r <= `SRC_INT_RC;
            else if (wr_ctrl && (state_r == ST_RUN))
                src_r <= wr_data[`CTRL_SRC_MSB:`CTRL_SRC_LSB];
        end
    end

    // AXI4-Lite handshake state
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= `RESP_OKAY;
            rd_pend_r <= 1'b0;
            rd_addr_r <= 8'h00;
            rvalid_r <= 1'b0;
            rresp_r <= `RESP_OKAY;
            rdata_r <= 32'h00000000;
        end
        else
        begin
            if (wr_go)
            begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
            end
            else
            begin
                if (aw_hs)
                begin
                    aw_full_r <= 1'b1;
                    aw_addr_r <= s_axi_awaddr;
                end
                if (w_hs)
                begin
                    w_full_r <= 1'b1;
                    w_data_r <= s_axi_wdata;
                    w_strb_r <= s_axi_wstrb;
                end
                if (bvalid_r && s_axi_bready)
                    bvalid_r <= 1'b0;
            end
            // Read data waits one cycle for the backup memory
            if (ar_hs)
            begin
                rd_pend_r <= 1'b1;
                rd_addr_r <= s_axi_araddr;
            end
            else if (rd_pend_r)
            begin
                rd_pend_r <= 1'b0;
                rvalid_r <= 1'b1;
                rdata_r <= rd_mux;
                rresp_r <= (rd_known) ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (rvalid_r && s_axi_rready)
                rvalid_r <= 1'b0;
        end
    end

    assign rd_known = is_hit(rd_addr_r, `OFS_MODE_CTRL) || is_hit(rd_addr_r, `OFS_MODE_STAT)
        || is_hit(rd_addr_r, `OFS_IRQ_STAT) || is_hit(rd_addr_r, `OFS_IRQ_MASK)
        || is_backup(rd_addr_r);

    always @*
    begin
        rd_mux = 32'h00000000;
        if (is_hit(rd_addr_r, `OFS_MODE_CTRL))
            rd_mux = {26'h0, src_r, ctrl_r[3:0]};
        else if (is_hit(rd_addr_r, `OFS_MODE_STAT))
            rd_mux = {21'h0, supply_threshold_detector, periph_clk_en, core_clk_en,
                high_speed_external_oscillator_en, high_speed_internal_oscillator_en,
                pll_en, regulator_en, regulator_mode, state_r};
        else if (is_hit(rd_addr_r, `OFS_IRQ_STAT))
            rd_mux = {28'h0, irq_stat_r};
        else if (is_hit(rd_addr_r, `OFS_IRQ_MASK))
            rd_mux = {28'h0, irq_mask_r};
        else if (is_backup(rd_addr_r))
            rd_mux = {16'h0, bk_rdata};
    end

    // [RL17] ten retained 16-bit registers
    backup_store #(
        .DEPTH(BACKUP_DEPTH),
        .WIDTH(16),
        .AW(4)
    ) u_backup (
        .aclk(aclk),
        .backup_resetn(backup_resetn),
        .we(wr_bk),
        .be(wr_strb[1:0]),
        .waddr(wr_bk_ofs[5:2]),
        .wdata(wr_data[15:0]),
        .raddr(rd_bk_ofs[5:2]),
        .rdata(bk_rdata)
    );

    wire in_run = (state_r == ST_RUN);
    wire clocks_on = in_run || (state_r == ST_SLEEP);
    // [RL6] sleep stops core only
    assign core_clk_en = in_run;
    // [RL8] stop halts core-domain clocks
    assign periph_clk_en = clocks_on;
    assign pll_en = clocks_on && (src_r == `SRC_PLL);
    assign high_speed_internal_oscillator_en = clocks_on;
    assign high_speed_external_oscillator_en = clocks_on && (src_r != `SRC_INT_RC);
    // [RL15] low-speed domain never gated
    assign always_on_clk_en = 1'b1;
    // [RL5] [RL12] regulator off only in standby
    assign regulator_en = (state_r != ST_STANDBY);
    // [RL1] [RL2] [RL3] [RL4] [RL10] regulator state choice
    assign regulator_mode = (state_r == ST_STANDBY) ? `REG_POWER_DOWN :
        ((state_r == ST_STOP) && stop_lp) ? `REG_LOW_POWER : `REG_MAIN;
    assign sys_clk_src = src_r;
    assign core_domain_resetn = !core_rst_r;
    assign irq = |(irq_stat_r & irq_mask_r);
endmodule // low_power_mode_controller

//--- test/wake_src_model.sv
// Model of the core wait request and the wake sources
`timescale 1ns/1ps
module wake_src_model (
    input wire aclk,
    output reg wait_request,
    output reg periph_event,
    output reg [15:0] event_lines,
    output reg supply_threshold_detector,
    output reg calendar_alarm,
    output reg wakeup_pin,
    output reg independent_watchdog_reset,
    output reg external_reset_pin_n
);
    initial
    begin
        {wait_request, periph_event, event_lines} = 18'h0;
        {calendar_alarm, wakeup_pin, independent_watchdog_reset, external_reset_pin_n} = 4'h1;
        supply_threshold_detector = 1'b0;
    end

    // One-cycle pulse; the wakeup pin gets a single rising edge
    task pulse(input integer src, input integer idx);
    begin
        @(posedge aclk);
        case (src)
            0: periph_event <= 1'b1;
            1: event_lines[idx] <= 1'b1;
            2: calendar_alarm <= 1'b1;
            3: wakeup_pin <= 1'b1;
            4: independent_watchdog_reset <= 1'b1;
            5: external_reset_pin_n <= 1'b0;
            default: wait_request <= 1'b1;
        endcase
        @(posedge aclk);
        {wait_request, periph_event, event_lines} <= 18'h0;
        {calendar_alarm, wakeup_pin, independent_watchdog_reset, external_reset_pin_n} <= 4'h1;
    end
    endtask

    task set_det(input v);
    begin
        @(posedge aclk);
        supply_threshold_detector <= v;
        repeat (2) @(posedge aclk);
    end
    endtask
endmodule // wake_src_model

//--- test/low_power_mode_controller_chk.sv
// Checker for mode, regulator and clock-enable relations
`timescale 1ns/1ps
`include "lpm_consts.vh"
module lpm_chk #(
    parameter EVENT_LINES = 16
) (
    input wire aclk,
    input wire aresetn,
    input wire periph_event,
    input wire [EVENT_LINES-1:0] event_lines,
    input wire core_clk_en,
    input wire periph_clk_en,
    input wire pll_en,
    input wire high_speed_internal_oscillator_en,
    input wire high_speed_external_oscillator_en,
    input wire always_on_clk_en,
    input wire regulator_en,
    input wire [1:0] regulator_mode,
    input wire [1:0] sys_clk_src,
    input wire core_domain_resetn
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Mode decoded from the enables, since state is not a port
    wire in_sleep = periph_clk_en && !core_clk_en;
    wire in_stop = regulator_en && !periph_clk_en;
    wire fast_on = pll_en || high_speed_internal_oscillator_en || high_speed_external_oscillator_en;
    sequence stby_leave;
        !regulator_en ##1 regulator_en;
    endsequence
    sequence core_rst_pulse;
        ##[0:1] !core_domain_resetn ##1 core_domain_resetn;
    endsequence

    a_run_main: assert property (core_clk_en |-> regulator_en && regulator_mode == `REG_MAIN)
        else $error("run without main regulation");
    a_sleep_core_only: assert property (in_sleep |->
        regulator_mode == `REG_MAIN && high_speed_internal_oscillator_en)
        else $error("sleep gated more than the core");
    a_stop_osc_off: assert property (in_stop |->
        !fast_on && regulator_mode != `REG_POWER_DOWN)
        else $error("stop left a fast clock running");
    a_stby_pdown: assert property (!regulator_en |->
        regulator_mode == `REG_POWER_DOWN && !fast_on && !periph_clk_en)
        else $error("standby not powered down");
    a_reset_reg_on: assert property ($rose(aresetn) |->
        regulator_en && core_clk_en && sys_clk_src == `SRC_INT_RC)
        else $error("regulator off after reset");
    a_sleep_wake: assert property (in_sleep && periph_event |=> core_clk_en)
        else $error("peripheral event did not end sleep");
    a_stop_wake: assert property (in_stop && (|event_lines) |=> core_clk_en)
        else $error("event line did not end stop");
    a_stop_wake_rc: assert property (in_stop ##1 core_clk_en |-> sys_clk_src == `SRC_INT_RC)
        else $error("stop wake not on internal clock");
    a_sleep_keep_src: assert property (in_sleep ##1 core_clk_en |-> $stable(sys_clk_src))
        else $error("sleep wake changed clock source");
    a_stby_core_rst: assert property (stby_leave |-> core_rst_pulse)
        else $error("no core reset after standby");
    a_always_on: assert property (always_on_clk_en)
        else $error("always-on clock stopped");
endmodule // lpm_chk

bind low_power_mode_controller lpm_chk #(.EVENT_LINES(EVENT_LINES)) lpm_chk_inst (.aclk, .aresetn,
    .periph_event, .event_lines, .core_clk_en, .periph_clk_en, .pll_en,
    .high_speed_internal_oscillator_en, .high_speed_external_oscillator_en, .always_on_clk_en,
    .regulator_en, .regulator_mode, .sys_clk_src, .core_domain_resetn);

//--- test/low_power_mode_controller_tb.sv
// Self-checking bench for the low-power mode controller
`timescale 1ns/1ps
`include "lpm_consts.vh"
module low_power_mode_controller_tb;
    reg aclk, aresetn, backup_resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    reg s_axi_arvalid, s_axi_rready;
    reg [7:0] s_axi_awaddr, s_axi_araddr;
    reg [31:0] s_axi_wdata;
    reg [3:0] s_axi_wstrb;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp, regulator_mode, sys_clk_src;
    wire [31:0] s_axi_rdata;
    wire wait_request, periph_event, supply_threshold_detector, calendar_alarm, wakeup_pin;
    wire independent_watchdog_reset, external_reset_pin_n, core_clk_en, periph_clk_en, pll_en;
    wire high_speed_internal_oscillator_en, high_speed_external_oscillator_en, always_on_clk_en;
    wire regulator_en, core_domain_resetn, irq;
    wire [15:0] event_lines;
    integer err_total = 0, compares = 0, seed = 24, i, k;
    reg [33:0] rq[$];
    reg [33:0] bq[$];
    reg [15:0] bk[0:9];

    low_power_mode_controller low_power_mode_controller_inst (.*);
    wake_src_model wake_src_model_inst (.*);

    task wrap_up;
    begin
        if (err_total == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask

    task tmo;
    begin
        err_total = err_total + 1;
        wrap_up;
    end
    endtask

    task chk(input string nm, input [33:0] seen, input [33:0] exp);
    begin
        compares = compares + 1;
        if (seen !== exp)
        begin
            err_total = err_total + 1;
            $display("FAIL %0s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask

    // Expected status word: state, regulator, enables and gated clocks
    function [33:0] ms(input [1:0] s, input lp_r, input [1:0] c);
        reg r;
    begin
        r = (s < 2'h2);
        ms = 34'h10;
        ms[1:0] = s;
        ms[2] = (s == 2'h2) && lp_r;
        ms[5] = r && (c == `SRC_PLL);
        ms[6] = r;
        ms[7] = r && (c != `SRC_INT_RC);
        ms[8] = (s == 2'h0);
        ms[9] = r;
    end
    endfunction

    task wr(input [7:0] a, input [31:0] d, input [1:0] r);
        integer n;
    begin
        bq.push_back({32'h0, r});
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            n = n + 1;
        end
        while (s_axi_bvalid !== 1'b1 && n < 40);
        s_axi_bready <= 1'b0;
        if (n >= 40)
            tmo;
    end
    endtask

    task rd(input [7:0] a, input [33:0] e);
        integer n;
    begin
        rq.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            n = n + 1;
        end
        while (s_axi_rvalid !== 1'b1 && n < 40);
        s_axi_rready <= 1'b0;
        if (n >= 40)
            tmo;
    end
    endtask

    // Result watcher: oldest note against each answer
    always @(posedge aclk)
    begin
        if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
            chk("read", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
            chk("wresp", {32'h0, s_axi_bresp}, bq.pop_front());
    end

    task wait_run;
        integer n;
    begin
        for (n = 0; n < 20 && core_clk_en !== 1'b1; n = n + 1)
            @(posedge aclk);
        if (core_clk_en !== 1'b1)
            tmo;
    end
    endtask

    // One low-power round trip: request, check, wake, status
    task lp(input [31:0] ctl, input integer src, input [33:0] st, input [33:0] ib);
    begin
        wr(`OFS_MODE_CTRL, ctl, `RESP_OKAY);
        wake_src_model_inst.pulse(6, 0);
        repeat (2) @(posedge aclk);
        if (ctl[1:0] == `REQ_STANDBY)
        begin
            chk("reg_en", regulator_en, 34'h0);
            chk("stby_out", {regulator_mode, pll_en, periph_clk_en},
                {`REG_POWER_DOWN, 2'h0});
        end
        else
            rd(`OFS_MODE_STAT, st);
        wake_src_model_inst.pulse(src, $unsigned($random(seed)) % 16);
        wait_run;
        // Source kept only across Sleep; Standby clears the whole control word
        rd(`OFS_MODE_CTRL, {28'h0, ((ctl[1:0] == `REQ_SLEEP) ? ctl[5:4] : `SRC_INT_RC),
            ((ctl[1:0] == `REQ_STANDBY) ? 4'h0 : ctl[3:0])});
        rd(`OFS_IRQ_STAT, ib);
        wr(`OFS_IRQ_STAT, ib[31:0], `RESP_OKAY);
    end
    endtask

    initial
    begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    initial
    begin
        #200000;
        tmo;
    end

    initial
    begin
        {aresetn, backup_resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 50'h0;
        s_axi_wstrb = 4'hF;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        backup_resetn <= 1'b1;
        rd(`OFS_MODE_STAT, ms(2'h0, 1'b0, `SRC_INT_RC));
        rd(`OFS_IRQ_STAT, 34'h0);
        for (i = 0; i < 10; i = i + 1)
        begin
            bk[i] = 16'($random(seed));
            wr(8'(`OFS_BACKUP_BASE + 4 * i), {16'h0, bk[i]}, `RESP_OKAY);
        end
        for (i = 0; i < 10; i = i + 1)
            rd(8'(`OFS_BACKUP_BASE + 4 * i), {18'h0, bk[i]});
        rd(8'h68, {`RESP_SLVERR, 32'h0});
        wr(8'h20, 32'h1, `RESP_SLVERR);
        wr(`OFS_MODE_CTRL, 32'h20, `RESP_OKAY);
        rd(`OFS_MODE_STAT, ms(2'h0, 1'b0, `SRC_PLL));
        lp(32'h20, 0, ms(2'h1, 1'b0, `SRC_PLL), 34'h8);
        chk("clk_src", sys_clk_src, `SRC_PLL);
        for (k = 0; k < 2; k = k + 1)
            lp({26'h0, (k[0] ? `SRC_PLL : `SRC_EXT_OSC), 1'b0, k[0], `REQ_STOP}, k + 1,
                ms(2'h2, k[0], `SRC_INT_RC), 34'h2);
        for (k = 0; k < 4; k = k + 1)
            lp({30'h0, `REQ_STANDBY}, k + 2, 34'h0, 34'h4);
        rd(8'h4C, {18'h0, bk[3]});
        wake_src_model_inst.set_det(1'b1);
        wake_src_model_inst.set_det(1'b0);
        rd(`OFS_IRQ_STAT, 34'h0);
        wr(`OFS_MODE_CTRL, 32'h8, `RESP_OKAY);
        wr(`OFS_IRQ_MASK, 32'h1, `RESP_OKAY);
        chk("irq_idle", irq, 34'h0);
        wake_src_model_inst.set_det(1'b1);
        rd(`OFS_MODE_STAT, ms(2'h0, 1'b0, `SRC_INT_RC) | 34'h400);
        rd(`OFS_IRQ_STAT, 34'h1);
        @(negedge aclk);
        chk("irq_set", irq, 34'h1);
        wake_src_model_inst.set_det(1'b0);
        wr(`OFS_IRQ_STAT, 32'h1, `RESP_OKAY);
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        chk("irq_clr", irq, 34'h0);
        // Core reset while in Standby must bring the regulator back
        wr(`OFS_MODE_CTRL, {30'h0, `REQ_STANDBY}, `RESP_OKAY);
        wake_src_model_inst.pulse(6, 0);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`OFS_MODE_STAT, ms(2'h0, 1'b0, `SRC_INT_RC));
        rd(8'h40, {18'h0, bk[0]});
        wrap_up;
    end
endmodule // low_power_mode_controller_tb
